/* File: adc_host_model.sv */
// Host model: link clock source, chain input and data capture
`timescale 1ns/1ps
module adc_host_model (
	input  wire logic mclk,
	input  wire logic serial_data,
	input  wire logic shift_clock_out,
	input  wire logic shift_clock_oe_n,
	input  wire logic frame_sync,
	output logic      shift_clock_in,
	output logic      tag_out
);
	logic [63:0] rx_reg = 64'h0;
	logic        last_bit = 1'b0;
	int          rx_count = 0;
	int          sync_count = 0;
	int          edge_errs = 0;
	wire         pin_level;

	initial begin
		shift_clock_in = 1'b0;
		tag_out = 1'b0;
	end

	// Pin level from whichever party drives the clock
	assign pin_level = shift_clock_oe_n ? shift_clock_in : shift_clock_out;

	// Capture data at each rising clock edge
	always @(posedge pin_level) begin
		rx_reg <= {rx_reg[62:0], serial_data};
		last_bit <= serial_data;
		rx_count <= rx_count + 1;
	end

	// A driven clock must find the same bit at its falling edge
	always @(negedge pin_level) begin
		if (!shift_clock_oe_n && serial_data !== last_bit)
			edge_errs <= edge_errs + 1;
	end

	// Length of the frame pulse in system cycles
	always @(posedge mclk) begin
		if (frame_sync === 1'b1)
			sync_count <= sync_count + 1;
	end

	// Run n clock periods, clock low between frames; chain input low
	// after rise m
	task automatic run_clock(input int n, input int m);
		for (int i = 0; i < n; i++) begin
			shift_clock_in = 1'b1;
			#160;
			shift_clock_in = 1'b0;
			if (i == m)
				tag_out = 1'b0;
			#160;
		end
	endtask
endmodule

/* File: adc_pkg.sv */
// Constants and state types for the serial conversion port
package adc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;
	localparam int CONV_TIME_NS   = 7600;
	localparam int BUSY_DELAY_NS  = 220;
	localparam int LEAD_TIME_NS   = 450;
	localparam int SCLK_PERIOD_NS = 440;

	localparam logic [7:0] CONV_CYC  = 8'(CONV_TIME_NS / CLK_PERIOD_NS);
	localparam logic [7:0] BUSY_CYC  = 8'(BUSY_DELAY_NS / CLK_PERIOD_NS);
	localparam logic [7:0] LEAD_CYC  = 8'(LEAD_TIME_NS / CLK_PERIOD_NS);
	localparam logic [7:0] SCLK_CYC  = 8'(SCLK_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [7:0] HIGH_CYC  = 8'(SCLK_CYC / 2);
	localparam logic [7:0] LOW_CYC   = 8'(SCLK_CYC - HIGH_CYC);
	localparam logic [7:0] MID_CYC   = 8'(LOW_CYC / 2);
	// Push and latch each take one cycle of the busy delay
	localparam logic [7:0] TAIL_CYC  = 8'(BUSY_CYC - 8'h02);

	// ------------------------------------------------------------
	// Word, buffer and pin layout
	// ------------------------------------------------------------
	localparam int         WORD_BITS  = 16;
	localparam int         FIFO_DEPTH = 8;
	localparam logic [4:0] LAST_BIT   = 5'(WORD_BITS - 1);
	localparam logic [4:0] PULSES     = 5'(WORD_BITS);
	localparam logic [15:0] WORD_RST  = 16'h0000;

	localparam int PIN_CS    = 0;
	localparam int PIN_RC    = 1;
	localparam int PIN_EXT   = 2;
	localparam int PIN_FMT   = 3;
	localparam int PIN_PD    = 4;
	localparam int PIN_TAG   = 5;
	localparam int PIN_SCLK  = 6;
	localparam int PIN_COUNT = 7;

	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		C_IDLE  = 5'h01,
		C_CONV  = 5'h02,
		C_PUSH  = 5'h04,
		C_LATCH = 5'h08,
		C_DELAY = 5'h10
	} conv_state_t;

	typedef enum logic [5:0] {
		T_IDLE  = 6'h01,
		T_LEAD  = 6'h02,
		T_HIGH  = 6'h04,
		T_LOW   = 6'h08,
		T_EWAIT = 6'h10,
		T_ERUN  = 6'h20
	} tx_state_t;

endpackage

/* File: adc_serial_port.sv */
// Conversion control and serial output port of a 16-bit sampling ADC
//
// Summary of operation
// - With chip select low, a read/convert fall holds the sample and starts a conversion.
// - In internal clock mode that start also begins sending the previous result.
// - In external mode, read/convert rising with select low, or select falling with read/convert high, gives a frame pulse on the prior result's first bit.
// - Chip select and read/convert are combined by OR, acting only when both are low.
// - Busy falls at conversion start and stays low until the tail of the busy delay after the result is latched has run.
// - Power-down refuses conversion starts; a conversion already running still completes and updates the held result.
// - In external mode, after 16 bits the chain input level is passed to the data output while select is low and read/convert high.
// - In external mode, chain input bits reappear on data 16 serial clocks later.
// - In internal mode each data bit stays valid over both edges of the serial clock.
// - In internal mode, between transfers, data holds the chain level taken at conversion start.
// - In internal mode the first serial clock edge follows the busy fall by 11 system cycles, 440 ns.
// - Busy rises 200 ns (5 system cycles) after the conversion ends.
// - In internal mode exactly 16 serial clock pulses are sent, low between transfers.
// - Clock source select high takes the serial clock from the host, low drives it out.
// - Output format select high gives straight binary, low two's complement.
`timescale 1ns/1ps
module adc_serial_port (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        CS_N,
	input  wire logic        READ_CONVERT,
	input  wire logic        CLOCK_SOURCE_SELECT,
	input  wire logic        OUTPUT_FORMAT_SELECT,
	input  wire logic        POWER_DOWN_INPUT,
	input  wire logic        TAG_IN,
	input  wire logic        SHIFT_CLOCK_IN,
	input  wire logic [15:0] SAR_RESULT,
	output logic             BUSY,
	output logic             SAMPLE_HOLD,
	output logic             FRAME_SYNC,
	output logic             SERIAL_DATA,
	output logic             SHIFT_CLOCK_OUT,
	output logic             SHIFT_CLOCK_OE_N
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	logic [adc_pkg::PIN_COUNT-1:0] pins_raw;
	logic [adc_pkg::PIN_COUNT-1:0] pins_s;

	assign pins_raw = {SHIFT_CLOCK_IN, TAG_IN, POWER_DOWN_INPUT,
		OUTPUT_FORMAT_SELECT, CLOCK_SOURCE_SELECT, READ_CONVERT, CS_N};

	pin_filter #(
		.WIDTH    (adc_pkg::PIN_COUNT)
	) u_filter (
		.clk      (MCLK),
		.reset_n  (RESET_N),
		.pins     (pins_raw),
		.filtered (pins_s)
	);

	logic cs_n_s;
	logic rc_s;
	logic ext_s;
	logic fmt_s;
	logic pd_s;
	logic tag_s;
	logic sclk_s;

	assign cs_n_s = pins_s[adc_pkg::PIN_CS];
	assign rc_s   = pins_s[adc_pkg::PIN_RC];
	assign ext_s  = pins_s[adc_pkg::PIN_EXT];
	assign fmt_s  = pins_s[adc_pkg::PIN_FMT];
	assign pd_s   = pins_s[adc_pkg::PIN_PD];
	assign tag_s  = pins_s[adc_pkg::PIN_TAG];
	assign sclk_s = pins_s[adc_pkg::PIN_SCLK];

	// ------------------------------------------------------------
	// State and registers
	// ------------------------------------------------------------
	adc_pkg::conv_state_t conv_state;
	adc_pkg::conv_state_t conv_next;
	adc_pkg::tx_state_t   tx_state;
	adc_pkg::tx_state_t   tx_next;

	logic [7:0]  conv_cnt_reg;
	logic [7:0]  conv_cnt_next;
	logic [7:0]  tx_cnt_reg;
	logic [7:0]  tx_cnt_next;
	logic [4:0]  bit_cnt_reg;
	logic [4:0]  bit_cnt_next;
	logic [15:0] result_reg;
	logic [15:0] shift_reg;
	logic [15:0] shift_next;
	logic        tag_hold_reg;
	logic        or_prev_reg;
	logic        arm_prev_reg;
	logic        sclk_prev_reg;
	logic        busy_reg;
	logic        hold_reg;
	logic        sync_reg;
	logic        sync_next;
	logic        data_reg;
	logic        data_next;
	logic        sclk_reg;
	logic        oe_n_reg;

	// ------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------
	logic or_n;
	logic arm_lvl;
	logic start_evt;
	logic restart;
	logic ext_trig;
	logic sclk_rise;
	logic conv_done;
	logic tail_done;
	logic phase_done;
	logic tx_load;
	logic mid_shift;
	logic showing;
	logic [15:0] push_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic pop;

	// Select and read/convert act as one OR'ed strobe
	assign or_n      = cs_n_s | rc_s;
	assign start_evt = or_prev_reg & !or_n & !pd_s &
		(conv_state == adc_pkg::C_IDLE);
	assign tail_done = conv_cnt_reg == adc_pkg::TAIL_CYC - 8'h01;
	// Both inputs still low at the end of the busy delay: convert again at once, busy stays low
	assign restart   = !or_n & !pd_s;
	assign conv_done = conv_cnt_reg == adc_pkg::CONV_CYC - 8'h01;
	// Select low with read/convert high, newly reached
	assign arm_lvl   = !cs_n_s & rc_s;
	assign ext_trig  = arm_lvl & !arm_prev_reg & ext_s;
	assign sclk_rise = sclk_s & !sclk_prev_reg;
	assign tx_load   = (tx_state == adc_pkg::T_IDLE) &
		(tx_next != adc_pkg::T_IDLE);
	assign mid_shift = (tx_state == adc_pkg::T_LOW) &
		(tx_cnt_reg == adc_pkg::MID_CYC) &
		(bit_cnt_reg != adc_pkg::LAST_BIT);

	// Result coding on the way into the buffer
	assign push_word = fmt_s ? SAR_RESULT :
		{~SAR_RESULT[15], SAR_RESULT[14:0]};
	// Held word is separate from the shifter, so a read in flight is safe
	assign pop = (conv_state == adc_pkg::C_LATCH) & fifo_out_valid;

	word_fifo #(
		.WIDTH     (adc_pkg::WORD_BITS),
		.DEPTH     (adc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (MCLK),
		.reset_n   (RESET_N),
		.in_valid  (conv_state == adc_pkg::C_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out_data)
	);

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------
	always_comb begin
		conv_next = conv_state;
		case (conv_state)
			adc_pkg::C_IDLE:
				if (start_evt)
					conv_next = adc_pkg::C_CONV;
			adc_pkg::C_CONV:
				if (conv_done)
					conv_next = adc_pkg::C_PUSH;
			adc_pkg::C_PUSH:
				if (fifo_in_ready)
					conv_next = adc_pkg::C_LATCH;
			adc_pkg::C_LATCH:
				if (pop)
					conv_next = adc_pkg::C_DELAY;
			adc_pkg::C_DELAY:
				if (tail_done)
					conv_next = restart ? adc_pkg::C_CONV :
						adc_pkg::C_IDLE;
			default:
				conv_next = adc_pkg::C_IDLE;
		endcase
	end

	assign conv_cnt_next = (conv_next != conv_state) ? 8'h00 :
		conv_cnt_reg + 8'h01;

	// Sequencer registers, busy and hold outputs
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			conv_state   <= adc_pkg::C_IDLE;
			conv_cnt_reg <= 8'h00;
			busy_reg     <= 1'b1;
			hold_reg     <= 1'b0;
		end else begin
			conv_state   <= conv_next;
			conv_cnt_reg <= conv_cnt_next;
			busy_reg     <= conv_next == adc_pkg::C_IDLE;
			hold_reg     <= conv_next == adc_pkg::C_CONV;
		end
	end

	// Held result, updated only at the latch step, so untouched while powered down and idle
	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			result_reg <= adc_pkg::WORD_RST;
		else if (pop)
			result_reg <= fifo_out_data;
	end

	// ------------------------------------------------------------
	// Serial transmitter
	// ------------------------------------------------------------
	assign phase_done = (tx_state == adc_pkg::T_LEAD) ?
		(tx_cnt_reg == adc_pkg::LEAD_CYC - 8'h01) :
		(tx_state == adc_pkg::T_HIGH) ?
		(tx_cnt_reg == adc_pkg::HIGH_CYC - 8'h01) :
		(tx_cnt_reg == adc_pkg::LOW_CYC - 8'h01);

	always_comb begin
		tx_next = tx_state;
		case (tx_state)
			adc_pkg::T_IDLE:
				if (start_evt & !ext_s)
					tx_next = adc_pkg::T_LEAD;
				else if (ext_trig)
					tx_next = adc_pkg::T_EWAIT;
			adc_pkg::T_LEAD:
				if (phase_done)
					tx_next = adc_pkg::T_HIGH;
			adc_pkg::T_HIGH:
				if (phase_done)
					tx_next = adc_pkg::T_LOW;
			adc_pkg::T_LOW:
				if (phase_done)
					tx_next = (bit_cnt_reg == adc_pkg::LAST_BIT) ?
						adc_pkg::T_IDLE : adc_pkg::T_HIGH;
			adc_pkg::T_EWAIT:
				if (!arm_lvl)
					tx_next = adc_pkg::T_IDLE;
				else if (sclk_rise)
					tx_next = adc_pkg::T_ERUN;
			adc_pkg::T_ERUN:
				if (!arm_lvl)
					tx_next = adc_pkg::T_IDLE;
			default:
				tx_next = adc_pkg::T_IDLE;
		endcase
	end

	// Counters, shifter and line levels
	assign tx_cnt_next = (tx_next != tx_state) ? 8'h00 :
		tx_cnt_reg + 8'h01;
	assign bit_cnt_next = tx_load ? 5'h00 :
		((tx_state == adc_pkg::T_LOW) & phase_done) ?
		bit_cnt_reg + 5'h01 : bit_cnt_reg;
	// Chain input enters low end, leaves 16 clocks later
	assign shift_next = tx_load ? result_reg :
		mid_shift ? {shift_reg[14:0], 1'b0} :
		((tx_state == adc_pkg::T_ERUN) & sclk_rise) ?
		{shift_reg[14:0], tag_s} : shift_reg;
	assign sync_next = (tx_next == adc_pkg::T_ERUN) &
		((tx_state == adc_pkg::T_EWAIT) | (sync_reg & !sclk_rise));
	assign showing = (tx_next == adc_pkg::T_LEAD) |
		(tx_next == adc_pkg::T_HIGH) | (tx_next == adc_pkg::T_LOW) |
		(tx_next == adc_pkg::T_ERUN);
	assign data_next = showing ? shift_next[15] : tag_hold_reg;

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			tx_state    <= adc_pkg::T_IDLE;
			tx_cnt_reg  <= 8'h00;
			bit_cnt_reg <= 5'h00;
			shift_reg   <= adc_pkg::WORD_RST;
		end else begin
			tx_state    <= tx_next;
			tx_cnt_reg  <= tx_cnt_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
		end
	end

	// Edge history, chain level and output pins
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			or_prev_reg   <= 1'b0;
			arm_prev_reg  <= 1'b0;
			sclk_prev_reg <= 1'b0;
			tag_hold_reg  <= 1'b0;
			sync_reg      <= 1'b0;
			data_reg      <= 1'b0;
			sclk_reg      <= 1'b0;
			oe_n_reg      <= 1'b1;
		end else begin
			or_prev_reg   <= or_n;
			arm_prev_reg  <= arm_lvl;
			sclk_prev_reg <= sclk_s;
			if (start_evt)
				tag_hold_reg <= tag_s;
			sync_reg      <= sync_next;
			data_reg      <= data_next;
			sclk_reg      <= tx_next == adc_pkg::T_HIGH;
			oe_n_reg      <= ext_s;
		end
	end

	assign BUSY             = busy_reg;
	assign SAMPLE_HOLD      = hold_reg;
	assign FRAME_SYNC       = sync_reg;
	assign SERIAL_DATA      = data_reg;
	assign SHIFT_CLOCK_OUT  = sclk_reg;
	assign SHIFT_CLOCK_OE_N = oe_n_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [7:0] lead_len_reg;
	logic [4:0] pulse_cnt_reg;
	logic [7:0] gap_reg;

	// Helper counts for lead time, pulses and busy tail
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			lead_len_reg  <= 8'h00;
			pulse_cnt_reg <= 5'h00;
			gap_reg       <= 8'h00;
		end else begin
			lead_len_reg  <= (tx_state == adc_pkg::T_LEAD) ?
				lead_len_reg + 8'h01 : 8'h00;
			pulse_cnt_reg <= tx_load ? 5'h00 :
				(sclk_reg & !$past(sclk_reg)) ?
				pulse_cnt_reg + 5'h01 : pulse_cnt_reg;
			gap_reg       <= (conv_state == adc_pkg::C_CONV) ? 8'h00 :
				gap_reg + 8'h01;
		end
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);

	sequence s_start;
		start_evt;
	endsequence
	sequence s_lead_end;
		$fell(tx_state == adc_pkg::T_LEAD);
	endsequence
	sequence s_tx_end;
		$fell(tx_state == adc_pkg::T_LOW) ##0 tx_state == adc_pkg::T_IDLE;
	endsequence

	a_start_hold: assert property (
		s_start |=> !busy_reg && hold_reg)
		else $error("start did not enter hold with busy low");
	a_int_tx_start: assert property (
		s_start ##0 !ext_s |=> tx_state == adc_pkg::T_LEAD)
		else $error("internal transfer did not start");
	a_ext_frame: assert property (
		tx_state == adc_pkg::T_EWAIT && sclk_rise && arm_lvl
		|=> sync_reg && data_reg == shift_reg[15])
		else $error("frame pulse or first bit missing");
	a_or_gate: assert property (
		conv_state == adc_pkg::C_IDLE && or_n
		|=> conv_state == adc_pkg::C_IDLE)
		else $error("conversion started with select or r/c high");
	a_busy_low: assert property (
		conv_state != adc_pkg::C_IDLE && conv_state != adc_pkg::C_DELAY
		|-> !busy_reg)
		else $error("busy high during conversion");
	a_pd_block: assert property (
		pd_s && conv_state == adc_pkg::C_IDLE
		|=> conv_state == adc_pkg::C_IDLE && $stable(result_reg))
		else $error("conversion or result change in power-down");
	a_chain_pass: assert property (
		tx_state == adc_pkg::T_ERUN && sclk_rise && arm_lvl
		|=> shift_reg[0] == $past(tag_s))
		else $error("chain bit not taken into shifter");
	a_bit_steady: assert property (
		$changed(sclk_reg) |-> $stable(data_reg))
		else $error("data changed on a serial clock edge");
	a_idle_tag: assert property (
		!ext_s && tx_state == adc_pkg::T_IDLE
		&& $past(tx_state) == adc_pkg::T_IDLE |-> data_reg == tag_hold_reg)
		else $error("idle data not at held chain level");
	a_lead_time: assert property (
		s_lead_end |-> lead_len_reg == adc_pkg::LEAD_CYC && sclk_reg)
		else $error("lead time before first clock wrong");
	a_busy_rise: assert property (
		$rose(busy_reg) |-> gap_reg == adc_pkg::BUSY_CYC)
		else $error("busy rise delay wrong");
	a_pulse_total: assert property (
		s_tx_end |-> pulse_cnt_reg == adc_pkg::PULSES && !sclk_reg)
		else $error("wrong number of serial clock pulses");
	a_clk_source: assert property (
		ext_s [*2] |-> oe_n_reg)
		else $error("shift clock driven in external mode");

endmodule

/* File: adc_serial_port_tb_top.sv */
// Self-checking bench for the serial conversion port
`timescale 1ns/1ps
module adc_serial_port_tb_top;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cs_n = 1'b1;
	logic        read_convert = 1'b1;
	logic        clock_source_select = 1'b0;
	logic        output_format_select = 1'b1;
	logic        power_down_input = 1'b0;
	logic [15:0] sar_result = 16'h0000;
	logic        busy;
	logic        sample_hold;
	logic        frame_sync;
	logic        serial_data;
	logic        shift_clock_out;
	logic        shift_clock_oe_n;
	logic        shift_clock_in;
	logic        tag_in;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          busy_cyc;
	int          hold_cyc;
	int          lead_cyc;

	adc_serial_port adc_serial_port_inst (
		.MCLK                (mclk),
		.RESET_N             (reset_n),
		.CS_N                (cs_n),
		.READ_CONVERT        (read_convert),
		.CLOCK_SOURCE_SELECT (clock_source_select),
		.OUTPUT_FORMAT_SELECT(output_format_select),
		.POWER_DOWN_INPUT    (power_down_input),
		.TAG_IN              (tag_in),
		.SHIFT_CLOCK_IN      (shift_clock_in),
		.SAR_RESULT          (sar_result),
		.BUSY                (busy),
		.SAMPLE_HOLD         (sample_hold),
		.FRAME_SYNC          (frame_sync),
		.SERIAL_DATA         (serial_data),
		.SHIFT_CLOCK_OUT     (shift_clock_out),
		.SHIFT_CLOCK_OE_N    (shift_clock_oe_n)
	);

	adc_host_model adc_host_model_inst (
		.mclk            (mclk),
		.serial_data     (serial_data),
		.shift_clock_out (shift_clock_out),
		.shift_clock_oe_n(shift_clock_oe_n),
		.frame_sync      (frame_sync),
		.shift_clock_in  (shift_clock_in),
		.tag_out         (tag_in)
	);

	// System clock
	initial begin
		forever #20 mclk = ~mclk;
	end

	// Compare and count
	task automatic check(input string name, input logic [32:0] exp,
			input logic [32:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Start a conversion by a select or read/convert fall and time it
	task automatic convert(input logic by_cs, input logic ext_read,
			input logic [15:0] word);
		int n;
		n = 0;
		adc_host_model_inst.rx_count = 0;
		@(negedge mclk);
		if (by_cs)
			read_convert = 1'b0;
		else
			cs_n = 1'b0;
		@(negedge mclk);
		cs_n = 1'b0;
		read_convert = 1'b0;
		while (busy !== 1'b0 && n < 10) begin
			@(negedge mclk);
			n++;
		end
		busy_cyc = 0;
		hold_cyc = 0;
		lead_cyc = 0;
		while (busy === 1'b0 && busy_cyc < 1000) begin
			if (busy_cyc == 5)
				read_convert = 1'b1;
			if (sample_hold === 1'b1)
				hold_cyc++;
			if (shift_clock_out === 1'b1 && lead_cyc == 0)
				lead_cyc = busy_cyc;
			busy_cyc++;
			@(negedge mclk);
		end
		if (n == 10 || busy_cyc == 1000) begin
			fail_count++;
			conclude();
		end
		if (!ext_read) begin
			check("busy low", adc_pkg::CONV_CYC + adc_pkg::BUSY_CYC,
				busy_cyc);
			check("hold", adc_pkg::CONV_CYC, hold_cyc);
			check("busy delay", adc_pkg::BUSY_CYC, busy_cyc - hold_cyc);
			check("lead", adc_pkg::LEAD_CYC, lead_cyc);
			check("pulses", adc_pkg::WORD_BITS,
				adc_host_model_inst.rx_count);
			check("word", word, adc_host_model_inst.rx_reg[15:0]);
			check("edge", 33'h0, adc_host_model_inst.edge_errs);
			check("clock enable", 33'h0, shift_clock_oe_n);
		end
	endtask

	// One framed read: data word, then chain bits delayed 16 clocks
	task automatic ext_frame(input logic [15:0] word);
		adc_host_model_inst.tag_out = 1'b1;
		adc_host_model_inst.sync_count = 0;
		repeat (10) @(negedge mclk);
		adc_host_model_inst.run_clock(34, 4);
		check("frame bits", {word, 4'hF, 13'h0000},
			adc_host_model_inst.rx_reg[32:0]);
		check("sync", 33'h8, adc_host_model_inst.sync_count);
		@(negedge mclk);
		cs_n = 1'b1;
	endtask

	// Internal clock: back-to-back transfers, format and chain hold
	task automatic internal_transfers();
		sar_result = 16'hA5C3;
		convert(1'b1, 1'b0, 16'h0000);
		adc_host_model_inst.tag_out = 1'b1;
		sar_result = 16'h1234;
		output_format_select = 1'b0;
		convert(1'b0, 1'b0, 16'hA5C3);
		check("idle data", 33'h1, serial_data);
		adc_host_model_inst.tag_out = 1'b0;
		repeat (10) @(negedge mclk);
		check("held tag", 33'h1, serial_data);
	endtask

	// Power-down refuses a start and keeps the held word
	task automatic power_down_hold();
		power_down_input = 1'b1;
		read_convert = 1'b0;
		repeat (20) @(negedge mclk);
		check("busy in power down", 33'h1, busy);
		read_convert = 1'b1;
		power_down_input = 1'b0;
		repeat (5) @(negedge mclk);
		sar_result = 16'hC0DE;
		output_format_select = 1'b1;
		convert(1'b0, 1'b0, 16'h9234);
	endtask

	// External clock: select fall, then read during a conversion
	task automatic external_frames();
		clock_source_select = 1'b1;
		cs_n = 1'b1;
		repeat (10) @(negedge mclk);
		check("clock enable", 33'h1, shift_clock_oe_n);
		cs_n = 1'b0;
		ext_frame(16'hC0DE);
		sar_result = 16'h0F0F;
		fork
			convert(1'b0, 1'b1, 16'h0000);
			begin
				repeat (30) @(negedge mclk);
				ext_frame(16'hC0DE);
			end
		join
	endtask

	// Main sequence
	initial begin
		repeat (5) @(negedge mclk);
		check("busy", 33'h1, busy);
		check("clock out", 33'h0, shift_clock_out);
		check("frame", 33'h0, frame_sync);
		reset_n = 1'b1;
		repeat (5) @(negedge mclk);
		internal_transfers();
		power_down_hold();
		external_frames();
		conclude();
	end
endmodule

/* File: pin_filter.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_filter #(
	parameter int WIDTH = 7
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] filtered
);

	// ------------------------------------------------------------
	// One chain per pin
	// ------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_reg;
		logic s2_reg;
		logic s3_reg;
		logic out_reg;

		// Output follows only when stages two and three agree
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				s1_reg  <= 1'b0;
				s2_reg  <= 1'b0;
				s3_reg  <= 1'b0;
				out_reg <= 1'b0;
			end else begin
				s1_reg <= pins[i];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				if (s2_reg == s3_reg)
					out_reg <= s3_reg;
			end
		end
		assign filtered[i] = out_reg;
	end

endmodule

/* File: word_fifo.sv */
// Result word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------
	// Handshake decode
	// ------------------------------------------------------------
	assign in_ready  = count_reg != (AW + 1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage write
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ?
					'0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ?
					'0 : rd_ptr_reg + 1'b1;
			if (push & !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop & !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule
